// file: csi_top.sv
`timescale 1ns/1ps
module csi_top #(
    parameter int unsigned STRETCH_LEN = csi_pkg::STRETCH_CYCLES,
    parameter int unsigned WAKE_LEN = csi_pkg::WAKE_CYCLES
) (
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    input wire logic usb_reset_i,
    input wire logic suspend_i,
    input wire logic dcp_detected_i,
    input wire logic tx_activity_i,
    input wire logic rx_activity_i,
    input wire logic ring_indicator_low_i,
    output logic [csi_pkg::PIN_COUNT-1:0] configurable_pins_o,
    output logic [csi_pkg::PIN_COUNT-1:0] configurable_pins_oe_n_o,
    output logic uart_pulldown_o,
    output logic hold_suspend_o,
    output logic remote_wake_o,
    output logic config_ready_o,
    output csi_pkg::csi_desc_type desc_o,
    output logic irq_o,
    input wire logic [csi_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [csi_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    import csi_pkg::*;
    logic [15:0] mem_reg [CFG_WORDS];
    csi_state_type state_reg;
    csi_desc_type desc_reg;
    logic [15:0] pins_cfg_reg, opts_reg;
    logic [1:0] load_idx_reg, wr_idx, rd_idx, bresp_reg, rresp_reg;
    logic [PIN_COUNT-1:0] pin_reg, pin_oe_n_reg;
    logic [IRQ_W-1:0] irq_status_reg, irq_mask_reg, irq_evt;
    logic [WAKE_CNT_W-1:0] wake_cnt_reg;
    logic [ADDR_W-1:0] aw_addr_reg;
    logic [31:0] w_data_reg, rdata_reg;
    logic [3:0] w_strb_reg;
    logic pulldown_reg, hold_reg, wake_reg, chg_prev_reg, susp_prev_reg, aw_got_reg, w_got_reg, bvalid_reg, rvalid_reg;
    logic tx_st, rx_st, charger, wr_fire, wr_cfg, wr_ok, reload, loaded_evt;
    csi_oneshot #(.LEN(STRETCH_LEN)) u_tx_shot (
        .ref_clk_i(ref_clk_i),
        .rst_n_i(rst_n_i),
        .trigger_i(tx_activity_i),
        .active_o(tx_st)
    );
    csi_oneshot #(.LEN(STRETCH_LEN)) u_rx_shot (
        .ref_clk_i(ref_clk_i),
        .rst_n_i(rst_n_i),
        .trigger_i(rx_activity_i),
        .active_o(rx_st)
    );

    assign charger = dcp_detected_i && suspend_i;
    assign wr_fire = aw_got_reg && w_got_reg && !bvalid_reg;
    assign wr_idx = aw_addr_reg[3:2];
    assign rd_idx = s_axi_araddr[3:2];
    assign wr_cfg = (aw_addr_reg >= REG_CFG_BASE) && (aw_addr_reg <= REG_CFG_LAST) && (aw_addr_reg[1:0] == 2'h0);
    assign wr_ok = wr_cfg || aw_addr_reg == REG_CTRL || aw_addr_reg == REG_IRQ_STATUS || aw_addr_reg == REG_IRQ_MASK;
    assign reload = usb_reset_i || (wr_fire && aw_addr_reg == REG_CTRL && w_strb_reg[0] && w_data_reg[CTRL_RELOAD]);
    assign loaded_evt = (state_reg == ST_LOAD) && (load_idx_reg == CFG_IDX_LAST) && !reload;

    // stored configuration; survives USB reset, rewritten only by software
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            mem_reg[CFG_IDX_PINS] <= CFG_PINS_RST;
            mem_reg[CFG_IDX_OPTS] <= CFG_OPTS_RST;
            mem_reg[CFG_IDX_VER] <= CFG_VER_RST;
            mem_reg[CFG_IDX_POWER] <= CFG_POWER_RST;
        end else if (wr_fire && wr_cfg) begin
            if (w_strb_reg[0]) begin
                mem_reg[wr_idx][7:0] <= w_data_reg[7:0];
            end
            if (w_strb_reg[1]) begin
                mem_reg[wr_idx][15:8] <= w_data_reg[15:8];
            end
        end
    end

    // scan one word per cycle; pins stay floating until done
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            state_reg <= ST_LOAD;
            load_idx_reg <= 2'h0;
            pins_cfg_reg <= 16'h0000;
            opts_reg <= 16'h0000;
            desc_reg <= '0;
        end else if (reload) begin
            state_reg <= ST_LOAD;
            load_idx_reg <= 2'h0;
        end else begin
            case (state_reg)
                ST_LOAD: begin
                    case (load_idx_reg)
                        CFG_IDX_PINS: pins_cfg_reg <= mem_reg[CFG_IDX_PINS];
                        CFG_IDX_OPTS: opts_reg <= mem_reg[CFG_IDX_OPTS];
                        CFG_IDX_VER: desc_reg.usb_version <= mem_reg[CFG_IDX_VER];
                        default: desc_reg.max_power_ma <= mem_reg[CFG_IDX_POWER];
                    endcase
                    desc_reg.self_powered <= opts_reg[OPT_SELF_POWERED];
                    desc_reg.full_speed_only <= 1'b1;
                    load_idx_reg <= load_idx_reg + 2'h1;
                    if (load_idx_reg == CFG_IDX_LAST) begin
                        state_reg <= ST_RUN;
                    end
                end
                ST_RUN: state_reg <= ST_RUN;
                default: state_reg <= ST_LOAD;
            endcase
        end
    end

    // pin function mux, registered so pins never glitch
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            pin_reg <= '0;
            pin_oe_n_reg <= '1;
        end else begin
            for (int i = 0; i < PIN_COUNT; i++) begin
                pin_reg[i] <= 1'b0;
                pin_oe_n_reg[i] <= 1'b1;
                if (state_reg == ST_RUN) begin
                    case (csi_fn_type'(pins_cfg_reg[i*FN_W +: FN_W]))
                        FN_TX_LED: pin_oe_n_reg[i] <= !tx_st;
                        FN_RX_LED: pin_oe_n_reg[i] <= !rx_st;
                        FN_TXRX_LED: pin_oe_n_reg[i] <= !(tx_st || rx_st);
                        FN_SLEEP: begin
                            pin_reg[i] <= !suspend_i;
                            pin_oe_n_reg[i] <= 1'b0;
                        end
                        FN_POWER_ENABLE_LOW: begin
                            pin_reg[i] <= suspend_i;
                            pin_oe_n_reg[i] <= 1'b0;
                        end
                        FN_CHARGER: begin
                            pin_reg[i] <= charger;
                            pin_oe_n_reg[i] <= 1'b0;
                        end
                        FN_CHARGER_LOW: begin
                            pin_reg[i] <= !charger;
                            pin_oe_n_reg[i] <= 1'b0;
                        end
                        default: pin_oe_n_reg[i] <= 1'b1;
                    endcase
                end
            end
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            pulldown_reg <= 1'b0;
            hold_reg <= 1'b0;
        end else begin
            pulldown_reg <= (state_reg == ST_RUN) && opts_reg[OPT_PULLDOWN] && suspend_i;
            hold_reg <= dcp_detected_i;
        end
    end

    // ring must stay low the whole wait; a bounce restarts it
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            wake_cnt_reg <= '0;
            wake_reg <= 1'b0;
        end else if (!(suspend_i && opts_reg[OPT_WAKE] && state_reg == ST_RUN)) begin
            wake_cnt_reg <= '0;
            wake_reg <= 1'b0;
        end else if (!ring_indicator_low_i && !wake_reg) begin
            if (wake_cnt_reg == WAKE_CNT_W'(WAKE_LEN - 1)) begin
                wake_reg <= 1'b1;
            end else begin
                wake_cnt_reg <= wake_cnt_reg + 1'b1;
            end
        end else if (!wake_reg) begin
            wake_cnt_reg <= '0;
        end
    end
    assign irq_evt[IRQ_LOADED] = loaded_evt;
    assign irq_evt[IRQ_CHARGER] = charger && !chg_prev_reg;
    assign irq_evt[IRQ_WAKE] = (wake_cnt_reg == WAKE_CNT_W'(WAKE_LEN - 1)) && !wake_reg && !ring_indicator_low_i;
    assign irq_evt[IRQ_SUSPEND] = suspend_i && !susp_prev_reg;

    // set beats a same-cycle write-one clear
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            irq_status_reg <= '0;
            irq_mask_reg <= '0;
            chg_prev_reg <= 1'b0;
            susp_prev_reg <= 1'b0;
        end else begin
            chg_prev_reg <= charger;
            susp_prev_reg <= suspend_i;
            if (wr_fire && aw_addr_reg == REG_IRQ_STATUS && w_strb_reg[0]) begin
                irq_status_reg <= (irq_status_reg & ~w_data_reg[IRQ_W-1:0]) | irq_evt;
            end else begin
                irq_status_reg <= irq_status_reg | irq_evt;
            end
            if (wr_fire && aw_addr_reg == REG_IRQ_MASK && w_strb_reg[0]) begin
                irq_mask_reg <= w_data_reg[IRQ_W-1:0];
            end
        end
    end

    // write channel: address and data latched independently
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            aw_got_reg <= 1'b0;
            w_got_reg <= 1'b0;
            aw_addr_reg <= '0;
            w_data_reg <= 32'h0000_0000;
            w_strb_reg <= 4'h0;
            bvalid_reg <= 1'b0;
            bresp_reg <= RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_got_reg <= 1'b1;
                aw_addr_reg <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_got_reg <= 1'b1;
                w_data_reg <= s_axi_wdata;
                w_strb_reg <= s_axi_wstrb;
            end
            if (wr_fire) begin
                aw_got_reg <= 1'b0;
                w_got_reg <= 1'b0;
                bvalid_reg <= 1'b1;
                bresp_reg <= wr_ok ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_bready) begin
                bvalid_reg <= 1'b0;
            end
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            rvalid_reg <= 1'b0;
            rdata_reg <= 32'h0000_0000;
            rresp_reg <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            rvalid_reg <= 1'b1;
            rresp_reg <= RESP_OKAY;
            rdata_reg <= 32'h0000_0000;
            if (s_axi_araddr == REG_STATE) begin
                rdata_reg[3:0] <= {charger, suspend_i, wake_reg, state_reg == ST_RUN};
            end else if (s_axi_araddr == REG_IRQ_STATUS) begin
                rdata_reg[IRQ_W-1:0] <= irq_status_reg;
            end else if (s_axi_araddr == REG_IRQ_MASK) begin
                rdata_reg[IRQ_W-1:0] <= irq_mask_reg;
            end else if (s_axi_araddr >= REG_CFG_BASE && s_axi_araddr <= REG_CFG_LAST
                         && s_axi_araddr[1:0] == 2'h0) begin
                rdata_reg[15:0] <= mem_reg[rd_idx];
            end else if (s_axi_araddr != REG_CTRL) begin
                rresp_reg <= RESP_SLVERR;
            end
        end else if (s_axi_rready) begin
            rvalid_reg <= 1'b0;
        end
    end

    assign s_axi_awready = !aw_got_reg && !bvalid_reg;
    assign s_axi_wready = !w_got_reg && !bvalid_reg;
    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp = bresp_reg;
    assign s_axi_arready = !rvalid_reg;
    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rdata = rdata_reg;
    assign s_axi_rresp = rresp_reg;
    assign configurable_pins_o = pin_reg;
    assign configurable_pins_oe_n_o = pin_oe_n_reg;
    assign uart_pulldown_o = pulldown_reg;
    assign hold_suspend_o = hold_reg;
    assign remote_wake_o = wake_reg;
    assign config_ready_o = (state_reg == ST_RUN);
    assign desc_o = desc_reg;
    assign irq_o = |(irq_status_reg & irq_mask_reg);
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rst_n_i);
    // pin config only moves while scanning, so a finished scan means a settled mux
    AST_CHARGER_HIGH: assert property (
        config_ready_o && pins_cfg_reg[7:4] == FN_CHARGER && charger |=> pin_reg[1] && !pin_oe_n_reg[1])
        else $error("charger pin not asserted");
    AST_CHARGER_LOW: assert property (
        config_ready_o && pins_cfg_reg[11:8] == FN_CHARGER_LOW && charger |=> !pin_reg[2] && !pin_oe_n_reg[2])
        else $error("low charger pin not asserted");
    AST_CHARGER_IDLE: assert property (
        config_ready_o && pins_cfg_reg[7:4] == FN_CHARGER && !suspend_i |=> !pin_reg[1])
        else $error("charger active while not suspended");
    AST_HOLD: assert property (dcp_detected_i |=> hold_suspend_o)
        else $error("charging port did not hold suspend");
    AST_LED_STRETCH: assert property (
        config_ready_o && pins_cfg_reg[11:8] == FN_TX_LED && tx_activity_i ##1 config_ready_o
        |=> (!configurable_pins_oe_n_o[2] && !configurable_pins_o[2])[*2])
        else $error("tx led not stretched");
    AST_LED_IDLE: assert property (
        config_ready_o && pins_cfg_reg[7:4] == FN_RX_LED && !rx_st |=> pin_oe_n_reg[1])
        else $error("idle rx led not floating");
    AST_TXRX: assert property (
        config_ready_o && pins_cfg_reg[3:0] == FN_TXRX_LED && (tx_st || rx_st) |=> !pin_oe_n_reg[0])
        else $error("combined led dark on activity");
    AST_LOAD: assert property ($rose(state_reg == ST_LOAD) |-> ##[4:5] config_ready_o)
        else $error("configuration scan length wrong");
    AST_PULLDOWN: assert property (uart_pulldown_o |-> $past(suspend_i) && opts_reg[OPT_PULLDOWN])
        else $error("pull-down outside enabled suspend");
    AST_WAKE: assert property (
        $rose(remote_wake_o) |-> $past(suspend_i) && $past(!ring_indicator_low_i) && opts_reg[OPT_WAKE])
        else $error("wake without cause");
    AST_SLEEP: assert property (
        config_ready_o && pins_cfg_reg[15:12] == FN_SLEEP |=> pin_reg[3] == !$past(suspend_i))
        else $error("sleep pin wrong level");
endmodule

// file: csi_pkg.sv
package csi_pkg;
    localparam int PIN_COUNT = 4;
    localparam int FN_W = 4;
    localparam int CFG_WORDS = 4;
    localparam logic [1:0] CFG_IDX_PINS = 2'h0;
    localparam logic [1:0] CFG_IDX_OPTS = 2'h1;
    localparam logic [1:0] CFG_IDX_VER = 2'h2;
    localparam logic [1:0] CFG_IDX_POWER = 2'h3;
    localparam logic [1:0] CFG_IDX_LAST = 2'h3;
    // per pin function, pin0 in the low nibble
    localparam logic [15:0] CFG_PINS_RST = 16'h4120;
    localparam logic [15:0] CFG_OPTS_RST = 16'h0000;
    localparam logic [15:0] CFG_VER_RST = 16'h0200;
    localparam logic [15:0] CFG_POWER_RST = 16'h005A;
    localparam int OPT_PULLDOWN = 0;
    localparam int OPT_WAKE = 1;
    localparam int OPT_SELF_POWERED = 2;

    localparam int CLK_HZ = 25_000_000;
    localparam int STRETCH_MS = 50;
    localparam int WAKE_MS = 20;
    localparam int STRETCH_CYCLES = CLK_HZ / 1000 * STRETCH_MS;
    localparam int WAKE_CYCLES = CLK_HZ / 1000 * WAKE_MS;
    localparam int WAKE_CNT_W = 20;

    localparam int ADDR_W = 8;
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STATE = 8'h04;
    localparam logic [7:0] REG_IRQ_STATUS = 8'h08;
    localparam logic [7:0] REG_IRQ_MASK = 8'h0C;
    localparam logic [7:0] REG_CFG_BASE = 8'h10;
    localparam logic [7:0] REG_CFG_LAST = 8'h1C;
    localparam int CTRL_RELOAD = 0;
    localparam int IRQ_W = 4;
    localparam int IRQ_LOADED = 0;
    localparam int IRQ_CHARGER = 1;
    localparam int IRQ_WAKE = 2;
    localparam int IRQ_SUSPEND = 3;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [FN_W-1:0] {
        FN_TRISTATE,
        FN_TX_LED,
        FN_RX_LED,
        FN_TXRX_LED,
        FN_SLEEP,
        FN_POWER_ENABLE_LOW,
        FN_CHARGER,
        FN_CHARGER_LOW
    } csi_fn_type;

    typedef enum logic {ST_LOAD, ST_RUN} csi_state_type;

    typedef struct packed {
        logic [15:0] usb_version;
        logic [15:0] max_power_ma;
        logic self_powered;
        logic full_speed_only;
    } csi_desc_type;
endpackage

// file: csi_oneshot.sv
`timescale 1ns/1ps
module csi_oneshot #(
    parameter int unsigned LEN = 16
) (
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    input wire logic trigger_i,
    output logic active_o
);
    localparam int CW = $clog2(LEN + 1);
    logic [CW-1:0] cnt_reg;

    // retrigger restarts the full length, so bursts read as one long pulse
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            cnt_reg <= '0;
        end else if (trigger_i) begin
            cnt_reg <= CW'(LEN);
        end else if (cnt_reg != '0) begin
            cnt_reg <= cnt_reg - 1'b1;
        end
    end

    assign active_o = (cnt_reg != '0);
endmodule

// file: csi_board.sv
`timescale 1ns/1ps
// board side of the pins: leds and charger enables hang on pull-ups
module csi_board (
    input wire logic [csi_pkg::PIN_COUNT-1:0] pins_i,
    input wire logic [csi_pkg::PIN_COUNT-1:0] oe_n_i,
    output logic [csi_pkg::PIN_COUNT-1:0] level_o
);
    import csi_pkg::*;
    // a released pin reads high, never the last driven value
    always_comb begin
        for (int i = 0; i < PIN_COUNT; i++) begin
            level_o[i] = oe_n_i[i] ? 1'h1 : pins_i[i];
        end
    end
endmodule

// file: tb_top.sv
`timescale 1ns/1ps
module tb_top;
    import csi_pkg::*;
    // short counts keep the run small
    localparam int SLEN = 8;
    localparam int WLEN = 10;
    logic ref_clk_i = 1'h0;
    logic rst_n_i = 1'h0;
    logic usb_reset_i = 1'h0;
    logic suspend_i = 1'h0;
    logic dcp_detected_i = 1'h0;
    logic tx_activity_i = 1'h0;
    logic rx_activity_i = 1'h0;
    logic ring_indicator_low_i = 1'h1;
    logic [3:0] pins, oe_n, lvl;
    logic uart_pulldown_o, hold_suspend_o, remote_wake_o, config_ready_o, irq_o;
    csi_desc_type desc_o;
    logic [7:0] awaddr = 8'h00;
    logic [7:0] araddr = 8'h00;
    logic [31:0] wdata = 32'h0000_0000;
    logic [31:0] rdata;
    logic awvalid = 1'h0;
    logic wvalid = 1'h0;
    logic bready = 1'h0;
    logic arvalid = 1'h0;
    logic rready = 1'h0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    int fails = 0;
    int samples_checked = 0;

    always #20 ref_clk_i = ~ref_clk_i;

    csi_top #(.STRETCH_LEN(SLEN), .WAKE_LEN(WLEN)) u_dut (
        .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .usb_reset_i(usb_reset_i), .suspend_i(suspend_i),
        .dcp_detected_i(dcp_detected_i), .tx_activity_i(tx_activity_i), .rx_activity_i(rx_activity_i),
        .ring_indicator_low_i(ring_indicator_low_i), .configurable_pins_o(pins),
        .configurable_pins_oe_n_o(oe_n), .uart_pulldown_o(uart_pulldown_o), .hold_suspend_o(hold_suspend_o),
        .remote_wake_o(remote_wake_o), .config_ready_o(config_ready_o), .desc_o(desc_o), .irq_o(irq_o),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready)
    );

    csi_board u_board (.pins_i(pins), .oe_n_i(oe_n), .level_o(lvl));

    task chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        samples_checked++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED at %0t: %s got %h expected %h", $time, msg, got, exp);
        end
    endtask

    // let the edge's updates land before looking
    task cyc(input int n);
        repeat (n) @(posedge ref_clk_i);
        #1;
    endtask

    task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        int k;
        @(posedge ref_clk_i);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        for (k = 0; k < 50; k++) begin
            @(posedge ref_clk_i);
            if (awvalid && awready) awvalid <= 1'h0;
            if (wvalid && wready) wvalid <= 1'h0;
            if (bvalid === 1'h1) break;
        end
        bready <= 1'h0;
        if (k == 50) fails++;
        chk(bresp, er, "write response");
    endtask

    task rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        int k;
        @(posedge ref_clk_i);
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        for (k = 0; k < 50; k++) begin
            @(posedge ref_clk_i);
            if (arvalid && arready) arvalid <= 1'h0;
            if (rvalid === 1'h1) break;
        end
        rready <= 1'h0;
        if (k == 50) fails++;
        chk(rdata, ed, "read data");
        chk(rresp, er, "read response");
    endtask

    task t_reset;
        chk(config_ready_o, 1'h0, "ready before scan");
        chk(oe_n, 4'hF, "pins float before scan");
        cyc(5);
        chk(config_ready_o, 1'h1, "ready after scan");
        chk(desc_o.usb_version, 16'h0200, "usb version");
        chk(desc_o.full_speed_only, 1'h1, "full speed");
        chk(desc_o.max_power_ma, 16'h005A, "max power");
        chk(desc_o.self_powered, 1'h0, "bus powered");
        chk(lvl[3], 1'h1, "sleep pin awake");
        rd(REG_CFG_BASE, 32'h0000_4120, RESP_OKAY);
        rd(REG_CFG_BASE + 8'h04, 32'h0000_0000, RESP_OKAY);
        rd(REG_CFG_LAST, 32'h0000_005A, RESP_OKAY);
        rd(8'h40, 32'h0000_0000, RESP_SLVERR);
    endtask

    task t_led;
        @(posedge ref_clk_i) tx_activity_i <= 1'h1;
        @(posedge ref_clk_i) tx_activity_i <= 1'h0;
        cyc(2);
        chk(lvl[2:1], 2'h1, "tx led lit, rx led dark");
        chk(oe_n[2], 1'h0, "tx led driven");
        cyc(SLEN - 4);
        chk(lvl[2], 1'h0, "single pulse still stretched");
        cyc(6);
        chk(oe_n[2], 1'h1, "tx led released");
        @(posedge ref_clk_i) suspend_i <= 1'h1;
        cyc(2);
        chk(lvl[3], 1'h0, "sleep pin in suspend");
        @(posedge ref_clk_i) suspend_i <= 1'h0;
        cyc(2);
        chk(lvl[3], 1'h1, "sleep pin resumed");
    endtask

    task t_cfg;
        // pin0 combined led, pin1 charger, pin2 charger low, pin3 power enable low
        wr(REG_CFG_BASE, 32'h0000_5763, RESP_OKAY);
        wr(REG_CFG_BASE + 8'h04, 32'h0000_0003, RESP_OKAY);
        wr(8'h40, 32'h0000_0001, RESP_SLVERR);
        wr(REG_IRQ_MASK, 32'h0000_0002, RESP_OKAY);
        @(posedge ref_clk_i) usb_reset_i <= 1'h1;
        @(posedge ref_clk_i) usb_reset_i <= 1'h0;
        cyc(7);
        chk(config_ready_o, 1'h1, "rescan done");
        @(posedge ref_clk_i) dcp_detected_i <= 1'h1;
        cyc(2);
        chk(hold_suspend_o, 1'h1, "stay suspended on charger port");
        chk(lvl[2:1], 2'h2, "charger idle while awake");
        chk(irq_o, 1'h0, "no charger event yet");
        @(posedge ref_clk_i) suspend_i <= 1'h1;
        cyc(2);
        chk(lvl[2:1], 2'h1, "charger asserted both senses");
        chk(lvl[3], 1'h1, "power enable high in suspend");
        chk(uart_pulldown_o, 1'h1, "uart pulled down");
        chk(irq_o, 1'h1, "charger event raised");
        wr(REG_IRQ_STATUS, 32'h0000_0002, RESP_OKAY);
        cyc(1);
        chk(irq_o, 1'h0, "charger event cleared");
        @(posedge ref_clk_i) ring_indicator_low_i <= 1'h0;
        cyc(WLEN - 4);
        chk(remote_wake_o, 1'h0, "wake not early");
        cyc(8);
        chk(remote_wake_o, 1'h1, "wake after ring low");
        rd(REG_STATE, 32'h0000_000F, RESP_OKAY);
        @(posedge ref_clk_i) rx_activity_i <= 1'h1;
        @(posedge ref_clk_i) rx_activity_i <= 1'h0;
        cyc(2);
        chk(lvl[0], 1'h0, "combined led on receive");
        @(posedge ref_clk_i) ring_indicator_low_i <= 1'h1;
        suspend_i <= 1'h0;
        dcp_detected_i <= 1'h0;
        cyc(2);
        chk(uart_pulldown_o, 1'h0, "pull-down off when awake");
        wr(REG_CTRL, 32'h0000_0001, RESP_OKAY);
        cyc(1);
        chk(config_ready_o, 1'h0, "software rescan started");
        cyc(3);
        chk(config_ready_o, 1'h1, "software rescan done");
    endtask

    task finish_test;
        $display("comparisons %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // whole run is well under a thousand cycles
    initial begin
        repeat (20000) @(posedge ref_clk_i);
        fails++;
        finish_test;
    end

    initial begin
        repeat (6) @(posedge ref_clk_i);
        rst_n_i <= 1'h1;
        cyc(1);
        t_reset;
        t_led;
        t_cfg;
        finish_test;
    end
endmodule
